// ---- rtl/eei_pkg.sv ----
package eei_pkg;

  // ----------------------------------------------------------------
  // Array geometry and instruction fields
  // ----------------------------------------------------------------
  localparam int ADDR_BITS_X8 = 7;
  localparam int DATA_BITS_X8 = 8;
  localparam int DATA_BITS_X16 = 16;
  localparam int HDR_FIXED_BITS = 3;
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] EXT_WRITE_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_WEN = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and array contents
  // ----------------------------------------------------------------
  localparam logic WEL_RESET = 1'b0;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PROG_TIME_MS = 4;
  localparam int PROG_CYC_DEF = int'(64'(PROG_TIME_MS) * 64'd1000000000 / 64'(CLK_PERIOD_PS));
  localparam int SELECT_LOW_TO_STATUS_DELAY_NS = 250;
  localparam int STATUS_DELAY_CYC = (SELECT_LOW_TO_STATUS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Read prefetch buffer
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CMD = 2'h1,
    ST_READ = 2'h2,
    ST_BUSY = 2'h3
  } eei_state_t;

endpackage

// ---- rtl/eei_store_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface eei_store_if #(
  parameter int AW = 6,
  parameter int DW = 16
);
  logic push_valid;
  logic push_ready;
  logic [DW-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [DW-1:0] pop_data;
  logic flush;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic [1:0] wr_be;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;

  modport core (output push_valid, push_data, pop_ready, flush, rd_en, rd_addr, wr_be, wr_addr, wr_data,
                input push_ready, pop_valid, pop_data, rd_data);
  modport fifo (input push_valid, push_data, pop_ready, flush, output push_ready, pop_valid, pop_data);
  modport mem (input rd_en, rd_addr, wr_be, wr_addr, wr_data, output rd_data);
endinterface
`default_nettype wire

// ---- rtl/eei_store.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Read prefetch FIFO
// ------------------------------------------------------------------
module eei_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  eei_store_if.fifo st
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slot_mem [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;
  logic full_w;
  logic empty_w;

  // Extra pointer bit tells full from empty
  assign empty_w = (wr_ptr_reg == rd_ptr_reg);
  assign full_w = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) && (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
  assign st.push_ready = ~full_w;
  assign st.pop_valid = ~empty_w;
  assign st.pop_data = slot_mem[rd_ptr_reg[PW-1:0]];

  // Pointers; flush drops stale prefetch when a read ends
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || st.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (st.push_valid && !full_w) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (st.pop_ready && !empty_w) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Storage
  always_ff @(posedge clock_i) begin
    if (st.push_valid && !full_w) slot_mem[wr_ptr_reg[PW-1:0]] <= st.push_data;
  end
endmodule

// ------------------------------------------------------------------
// Nonvolatile array model, word wide with byte lanes
// ------------------------------------------------------------------
module eei_mem
  import eei_pkg::*;
#(
  parameter int AW = 6
) (
  input wire logic clock_i,
  eei_store_if.mem st
);
  logic [15:0] cell_mem [2**AW];
  logic [15:0] rd_data_reg;

  // Delivered state: every bit erased
  initial begin
    for (int i = 0; i < 2**AW; i++) cell_mem[i] = ERASED_WORD; // see R19
  end

  assign st.rd_data = rd_data_reg;

  // Byte-lane write and registered read
  always_ff @(posedge clock_i) begin
    if (st.wr_be[1]) cell_mem[st.wr_addr][15:8] <= st.wr_data[15:8];
    if (st.wr_be[0]) cell_mem[st.wr_addr][7:0] <= st.wr_data[7:0];
    if (st.rd_en) rd_data_reg <= cell_mem[st.rd_addr];
  end
endmodule
`default_nettype wire

// ---- rtl/eei_core.sv ----
// Notes on behaviour
// R1: Start bit is first one sampled while selected
// R2: Op-codes read, write, erase, extended via address
// R3: Address width follows organization and array size
// R4: Read sends dummy zero then data MSB first
// R5: Read data changes on rising serial clock
// R6: Held select streams next location, address wraps
// R7: Writes disabled after reset
// R8: Enable allows writes until disable or reset
// R9: Write data bits sampled on rising clock
// R10: Select must fall right after last bit
// R11: Programming timed internally, clock not needed
// R12: Write erases location first automatically
// R13: Write-all programs value into every address
// R14: Erase sets addressed location to ones
// R15: Erase-all sets whole array to ones
// R16: Busy shows zero on output after delay
// R17: Inputs ignored while busy
// R18: Ready shows one until select falls or start
// R19: Delivered array reads all ones
// R20: Wrong pulse count aborts modifying instructions
// R21: Expected count is start+opcode+address+data
// R22: Modifying instructions ignored while writes disabled
// R23: Organization input selects byte or word mode
`timescale 1ns/10ps
`default_nettype none
module eei_core
  import eei_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_BITS_X8,
  parameter int PROG_CYCLES = PROG_CYC_DEF,
  parameter int FIFO_DEPTH_P = FIFO_DEPTH,
  parameter int STATUS_CYCLES = STATUS_DELAY_CYC
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic chip_sel_i,
  input wire logic ser_clk_i,
  input wire logic ser_din_i,
  input wire logic org_word_i,
  output logic ser_dout_o,
  output logic ser_dout_oe_o,
  output logic busy_o,
  output logic write_en_o
);
  localparam int WAW = ADDR_BITS - 1;
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam int SW = $clog2(STATUS_CYCLES + 1);

  function automatic logic [15:0] fld(input logic [31:0] v, input logic [4:0] lsb);
    fld = 16'(v >> lsb);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic sck_last_reg;
  logic cs_last_reg;
  logic cs_s;
  logic sck_s;
  logic din_s;
  logic org_s;

  // Pins are asynchronous to clock_i, two flops before any use
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
      sck_last_reg <= 1'b0;
      cs_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {org_word_i, ser_din_i, ser_clk_i, chip_sel_i};
      pin_sync_reg <= pin_meta_reg;
      sck_last_reg <= pin_sync_reg[1];
      cs_last_reg <= pin_sync_reg[0];
    end
  end

  assign cs_s = pin_sync_reg[0];
  assign sck_s = pin_sync_reg[1];
  assign din_s = pin_sync_reg[2];
  assign org_s = pin_sync_reg[3];

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  eei_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [31:0] sh_reg;
  logic [1:0] op_reg;
  logic [1:0] ext_reg;
  logic [ADDR_BITS-1:0] addr_reg;
  logic hdr_done_reg;
  logic wel_reg;
  logic ready_show_reg;

  logic rise;
  logic cs_fall;
  logic step;
  logic [4:0] ab_w;
  logic [4:0] dw_w;
  logic [5:0] hdr_w;
  logic [5:0] cnt_inc;
  logic [31:0] sh_shift;
  logic at_hdr;
  logic [1:0] op_now;
  logic [1:0] ext_now;
  logic [ADDR_BITS-1:0] addr_now;
  logic dec_read;
  logic dec_wen;
  logic dec_write_disable;
  logic is_write;
  logic is_erase;
  logic is_write_all;
  logic is_erase_all;
  logic has_data;
  logic is_mod;
  logic [5:0] exp_cnt;
  logic start_prog;
  logic start_bit;

  assign rise = sck_s & ~sck_last_reg & cs_s;
  assign cs_fall = cs_last_reg & ~cs_s;
  assign step = rise && (state_reg == ST_CMD);
  // Byte mode carries one more address bit than word mode
  assign ab_w = org_s ? 5'(ADDR_BITS - 1) : 5'(ADDR_BITS);                    // see R23
  assign dw_w = org_s ? 5'(DATA_BITS_X16) : 5'(DATA_BITS_X8);                 // see R23
  assign hdr_w = 6'(HDR_FIXED_BITS) + {1'b0, ab_w};                           // see R3
  assign cnt_inc = (cnt_reg == 6'h3F) ? cnt_reg : cnt_reg + 6'h01;
  assign sh_shift = {sh_reg[30:0], din_s};                                    // see R9
  assign at_hdr = step && !hdr_done_reg && (cnt_inc == hdr_w);
  assign op_now = 2'(fld(sh_shift, ab_w));                                    // see R2
  assign ext_now = 2'(fld(sh_shift, ab_w - 5'h02));
  assign addr_now = org_s ? {1'b0, sh_shift[WAW-1:0]} : sh_shift[ADDR_BITS-1:0];
  assign dec_read = at_hdr && (op_now == OPC_READ);
  assign dec_wen = at_hdr && (op_now == OPC_EXT) && (ext_now == EXT_WEN);
  assign dec_write_disable = at_hdr && (op_now == OPC_EXT) && (ext_now == EXT_WRITE_DISABLE);
  assign start_bit = rise && (state_reg == ST_IDLE) && din_s;                 // see R1

  // Pulse counter check at select fall
  assign is_write = (op_reg == OPC_WRITE);
  assign is_erase = (op_reg == OPC_ERASE);
  assign is_write_all = (op_reg == OPC_EXT) && (ext_reg == EXT_WRITE_ALL);
  assign is_erase_all = (op_reg == OPC_EXT) && (ext_reg == EXT_ERASE_ALL);
  assign has_data = is_write | is_write_all;
  assign is_mod = is_write | is_erase | is_write_all | is_erase_all;
  assign exp_cnt = has_data ? hdr_w + {1'b0, dw_w} : hdr_w;                   // see R21
  // Early or late select fall leaves a count mismatch and nothing starts
  assign start_prog = (state_reg == ST_CMD) && cs_fall && hdr_done_reg && is_mod
                      && wel_reg && (cnt_reg == exp_cnt);                     // see R10, R20, R22

  // ----------------------------------------------------------------
  // Store interface: prefetch FIFO and array
  // ----------------------------------------------------------------
  eei_store_if #(.AW(WAW), .DW(FIFO_WIDTH)) st ();

  eei_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH_P)) u_fifo (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .st(st.fifo)
  );

  eei_mem #(.AW(WAW)) u_mem (
    .clock_i(clock_i),
    .st(st.mem)
  );

  // ----------------------------------------------------------------
  // Programming engine
  // ----------------------------------------------------------------
  logic pg_all_reg;
  logic pg_erase_reg;
  logic [WAW-1:0] pg_word_reg;
  logic [1:0] pg_be_reg;
  logic [15:0] pg_data_reg;
  logic [WAW-1:0] sweep_reg;
  logic wr_act_reg;
  logic [TW-1:0] timer_reg;
  logic [WAW-1:0] word_sel;
  logic [1:0] be_sel;
  logic [15:0] data_in;
  logic prog_done;

  assign word_sel = org_s ? addr_reg[WAW-1:0] : addr_reg[ADDR_BITS-1:1];
  assign be_sel = org_s ? 2'h3 : (addr_reg[0] ? 2'h1 : 2'h2);
  // Byte data is copied to both lanes so write-all fills every byte
  assign data_in = org_s ? sh_reg[15:0] : {sh_reg[7:0], sh_reg[7:0]};
  assign prog_done = (state_reg == ST_BUSY) && (timer_reg == '0);

  // Lane write overwrites the old value: erase and write are one step
  assign st.wr_be = wr_act_reg ? pg_be_reg : 2'h0;                            // see R12
  assign st.wr_addr = pg_all_reg ? sweep_reg : pg_word_reg;                   // see R13, R15
  assign st.wr_data = pg_data_reg;

  // Capture the job at select fall
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pg_all_reg <= 1'b0;
      pg_erase_reg <= 1'b0;
      pg_word_reg <= '0;
      pg_be_reg <= 2'h0;
      pg_data_reg <= 16'h0000;
    end else if (start_prog) begin
      pg_all_reg <= is_write_all | is_erase_all;
      pg_erase_reg <= is_erase | is_erase_all;
      pg_word_reg <= word_sel;
      pg_be_reg <= (is_write_all | is_erase_all) ? 2'h3 : be_sel;
      pg_data_reg <= (is_erase | is_erase_all) ? ERASED_WORD : data_in;       // see R14, R15
    end
  end

  // Timer and sweep run on clock_i alone, serial clock may stop
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wr_act_reg <= 1'b0;
      sweep_reg <= '0;
      timer_reg <= '0;
    end else if (start_prog) begin
      wr_act_reg <= 1'b1;
      sweep_reg <= '0;
      timer_reg <= TW'(PROG_CYCLES - 1);                                      // see R11
    end else if (state_reg == ST_BUSY) begin
      if (wr_act_reg) sweep_reg <= sweep_reg + 1'b1;
      if (wr_act_reg && (!pg_all_reg || (&sweep_reg))) wr_act_reg <= 1'b0;
      if (timer_reg != '0) timer_reg <= timer_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
      hdr_done_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_bit) begin
            state_reg <= ST_CMD;
            cnt_reg <= 6'h01;
            hdr_done_reg <= 1'b0;
          end
        end
        ST_CMD: begin
          if (start_prog) state_reg <= ST_BUSY;
          else if (cs_fall) state_reg <= ST_IDLE;
          else if (dec_read) state_reg <= ST_READ;
          if (step) cnt_reg <= cnt_inc;
          if (at_hdr) hdr_done_reg <= 1'b1;
        end
        ST_READ: begin
          if (cs_fall) state_reg <= ST_IDLE;
        end
        ST_BUSY: begin
          if (prog_done) state_reg <= ST_IDLE;                                // see R17
        end
      endcase
    end
  end

  // Instruction shift register and latched fields
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sh_reg <= 32'h0;
      op_reg <= 2'h0;
      ext_reg <= 2'h0;
      addr_reg <= '0;
    end else begin
      if (start_bit) sh_reg <= 32'h0;
      else if (step) sh_reg <= sh_shift;
      if (at_hdr) begin
        op_reg <= op_now;
        ext_reg <= ext_now;
        addr_reg <= addr_now;
      end
    end
  end

  // Write-enable latch and ready flag
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wel_reg <= WEL_RESET;                                                   // see R7
      ready_show_reg <= 1'b0;
    end else begin
      if (dec_wen) wel_reg <= 1'b1;                                           // see R8
      else if (dec_write_disable) wel_reg <= 1'b0;
      // Completion sets, and wins over a clearing event in the same cycle
      if (prog_done) ready_show_reg <= 1'b1;
      else if (cs_fall || start_bit) ready_show_reg <= 1'b0;                  // see R18
    end
  end

  // ----------------------------------------------------------------
  // Read path: prefetch into FIFO, shift out on serial clock
  // ----------------------------------------------------------------
  logic [ADDR_BITS-1:0] pf_addr_reg;
  logic pf_pend_reg;
  logic pf_half_reg;
  logic [15:0] out_sh_reg;
  logic [4:0] bits_left_reg;
  logic rd_bit_reg;
  logic pf_issue;
  logic [ADDR_BITS-1:0] pf_inc;
  logic rd_step;
  logic [15:0] aligned;

  // One read outstanding, so the FIFO always has room for its reply
  assign pf_issue = (state_reg == ST_READ) && !pf_pend_reg && st.push_ready;
  assign pf_inc = org_s ? {1'b0, WAW'(pf_addr_reg[WAW-1:0] + 1'b1)} : pf_addr_reg + 1'b1;
  assign st.rd_en = pf_issue;
  assign st.rd_addr = org_s ? pf_addr_reg[WAW-1:0] : pf_addr_reg[ADDR_BITS-1:1];
  assign st.push_valid = pf_pend_reg && (state_reg == ST_READ);
  assign st.push_data = org_s ? st.rd_data : {8'h00, pf_half_reg ? st.rd_data[7:0] : st.rd_data[15:8]};
  assign st.flush = (state_reg != ST_READ);
  assign rd_step = rise && (state_reg == ST_READ);
  assign st.pop_ready = rd_step && (bits_left_reg == 5'h00) && st.pop_valid;
  assign aligned = org_s ? st.pop_data : {st.pop_data[7:0], 8'h00};

  // Prefetch address counts up and wraps inside the array
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pf_addr_reg <= '0;
      pf_pend_reg <= 1'b0;
      pf_half_reg <= 1'b0;
    end else if (dec_read) begin
      pf_addr_reg <= addr_now;
      pf_pend_reg <= 1'b0;
    end else if (state_reg != ST_READ) begin
      pf_pend_reg <= 1'b0;
    end else if (pf_issue) begin
      pf_pend_reg <= 1'b1;
      pf_half_reg <= pf_addr_reg[0];
      pf_addr_reg <= pf_inc;                                                  // see R6
    end else begin
      pf_pend_reg <= 1'b0;
    end
  end

  // Limitation: a master faster than the prefetch would see a held bit
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      out_sh_reg <= 16'h0000;
      bits_left_reg <= 5'h00;
      rd_bit_reg <= 1'b0;
    end else if (dec_read) begin
      rd_bit_reg <= 1'b0;                                                     // see R4
      bits_left_reg <= 5'h00;
    end else if (rd_step) begin
      if (bits_left_reg == 5'h00) begin
        if (st.pop_valid) begin
          rd_bit_reg <= aligned[15];                                          // see R5, R6
          out_sh_reg <= {aligned[14:0], 1'b0};
          bits_left_reg <= dw_w - 5'h01;
        end
      end else begin
        rd_bit_reg <= out_sh_reg[15];                                         // see R4
        out_sh_reg <= {out_sh_reg[14:0], 1'b0};
        bits_left_reg <= bits_left_reg - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pin and status
  // ----------------------------------------------------------------
  logic [SW-1:0] cs_cnt_reg;
  logic dout_next;
  logic oe_next;
  logic status_ok;

  assign status_ok = (cs_cnt_reg >= SW'(STATUS_CYCLES));

  // Select-high time, gates the busy level by the status delay
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !cs_s) cs_cnt_reg <= '0;
    else if (!status_ok) cs_cnt_reg <= cs_cnt_reg + 1'b1;
  end

  // Pin is released whenever select is low
  always_comb begin
    dout_next = 1'b1;
    oe_next = 1'b0;
    if (cs_s) begin
      if (state_reg == ST_BUSY) begin
        dout_next = 1'b0;                                                     // see R16
        oe_next = status_ok;
      end else if (state_reg == ST_READ) begin
        dout_next = rd_bit_reg;
        oe_next = 1'b1;
      end else if (ready_show_reg) begin
        oe_next = 1'b1;                                                       // see R18
      end
    end
  end

  logic dout_reg;
  logic oe_reg;
  logic busy_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      dout_reg <= 1'b1;
      oe_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      busy_reg <= (state_reg == ST_BUSY);
    end
  end

  assign ser_dout_o = dout_reg;
  assign ser_dout_oe_o = oe_reg;
  assign busy_o = busy_reg;
  assign write_en_o = wel_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_DUMMY_ZERO: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R4
    dec_read ##1 cs_s |=> (!ser_dout_o && ser_dout_oe_o))
    else $error("dummy zero missing");
  AST_WEL_RESET: assert property (@(posedge clock_i) !rst_b_i |=> !write_en_o) // see R7
    else $error("write enable not cleared by reset");
  AST_WEN_SETS: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R8
    dec_wen |=> write_en_o)
    else $error("enable instruction ignored");
  AST_NO_PROG_DISABLED: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R22
    (state_reg == ST_CMD) && cs_fall && !wel_reg |=> state_reg != ST_BUSY)
    else $error("program started while disabled");
  AST_COUNT_MATCH: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R20, R21
    $rose(state_reg == ST_BUSY) |-> $past(cnt_reg) == $past(exp_cnt))
    else $error("program started on wrong pulse count");
  AST_BUSY_HOLDS: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R11, R17
    start_prog |=> (state_reg == ST_BUSY)[*8])
    else $error("programming cycle cut short");
  AST_BUSY_IGNORES: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R17
    (state_reg == ST_BUSY) && rise |=> $stable(sh_reg) && $stable(cnt_reg))
    else $error("input taken while busy");
  AST_BUSY_LEVEL: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R16
    (state_reg == ST_BUSY) && cs_s && status_ok && !prog_done |=> ser_dout_oe_o && !ser_dout_o)
    else $error("busy level not shown");
  AST_READY_LEVEL: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R18
    prog_done ##1 (cs_s && (state_reg == ST_IDLE) && !start_bit) |=> ser_dout_oe_o && ser_dout_o)
    else $error("ready level not shown");
  AST_ERASE_ONES: assert property (@(posedge clock_i) disable iff (!rst_b_i) // see R14, R15
    (st.wr_be != 2'h0) && pg_erase_reg |-> st.wr_data == ERASED_WORD)
    else $error("erase writes zeros");

endmodule
`default_nettype wire

// ---- verification/eei_master.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Serial bus master model
// ----------------------------------------
module eei_master (
  input wire logic clock_i,
  input wire logic dout_i,
  output logic cs_o,
  output logic sclk_o,
  output logic din_o
);
  // Idle levels; link clock stands low outside frames
  initial begin
    cs_o = 1'b0;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // Select changes only while the link clock is low
  task automatic sel(input logic s);
    @(posedge clock_i);
    cs_o <= s;
    repeat (8) @(posedge clock_i);
  endtask
  // Shift n bits MSB first; q collects the output bit after each rise
  task automatic sh(input int n, input logic [31:0] v, output logic [31:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clock_i);
      din_o <= v[i];
      #32 sclk_o = 1'b1;
      #32 q = {q[30:0], dout_i};
      sclk_o = 1'b0;
    end
    din_o <= ~din_o; // Released line must not hold a stale value
  endtask
endmodule
`default_nettype wire

// ---- verification/eei_core_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module eei_core_bench;
  import eei_pkg::*;
  logic clock_i, rst_b_i, org, cs, sclk, din, dout, oe, busy, wen;
  int err_count, check_count;
  logic [7:0] mem [128];
  logic [31:0] q;
  logic [6:0] a;
  logic [7:0] d;
  eei_core #(.ADDR_BITS(7), .PROG_CYCLES(200), .STATUS_CYCLES(4)) eei_core_inst (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .chip_sel_i(cs), .ser_clk_i(sclk), .ser_din_i(din), .org_word_i(org),
    .ser_dout_o(dout), .ser_dout_oe_o(oe), .busy_o(busy), .write_en_o(wen));
  eei_master eei_master_inst (.clock_i(clock_i), .dout_i(dout), .cs_o(cs), .sclk_o(sclk), .din_o(din));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Modifying frame, then select high again to watch the status
  task automatic op(input int n, input logic [31:0] v, input logic prog);
    int t;
    eei_master_inst.sel(1'b1);
    eei_master_inst.sh(n, v, q);
    eei_master_inst.sel(1'b0);
    eei_master_inst.sel(1'b1);
    #1 chk("busy", busy, prog);
    if (prog) begin
      chk("busy_q", dout, 1'b0);
      chk("busy_oe", oe, 1'b1);
      eei_master_inst.sh(4, 32'hF, q);
      chk("busy_ign", q[3:0], 4'h0);
      t = 0;
      while (busy === 1'b1 && t < 400) begin
        @(posedge clock_i);
        t++;
      end
      chk("busy_end", busy, 1'b0);
      repeat (3) @(posedge clock_i);
      #1 chk("ready", dout, 1'b1);
      chk("oe", oe, 1'b1);
    end
    eei_master_inst.sel(1'b0);
  endtask
  // Sequential read of nb bytes, compared with the model
  task automatic rd(input int ad, input int nb);
    eei_master_inst.sel(1'b1);
    eei_master_inst.sh(10, {22'h0, 3'b110, 7'(ad)}, q);
    chk("dummy", q[0], 1'b0);
    for (int i = 0; i < nb; i++) begin
      eei_master_inst.sh(8, 32'h0, q);
      chk("rdata", q[7:0], mem[(ad + i) % 128]);
    end
    eei_master_inst.sel(1'b0);
  endtask
  // Hang guard, reckoned well above the expected run
  initial begin
    #400us;
    err_count++;
    finish_test;
  end
  initial begin
    err_count = 0;
    check_count = 0;
    rst_b_i = 1'b0;
    org = 1'b0;
    foreach (mem[i]) mem[i] = 8'hFF;
    void'($urandom(16656));
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    #1 chk("wen_rst", wen, 1'b0);
    rd(126, 3);
    op(18, {14'h0, 3'b101, 7'h05, 8'h00}, 1'b0);
    op(10, {22'h0, 3'b100, 7'h60}, 1'b0);
    chk("wen", wen, 1'b1);
    $display("test enable done");
    repeat (4) begin
      a = 7'($urandom);
      d = 8'($urandom);
      op(18, {14'h0, 3'b101, a, d}, 1'b1);
      mem[a] = d;
      rd(int'(a), 2);
    end
    org <= 1'b1;
    op(25, {7'h0, 3'b101, a[6:1], 8'h5A, d}, 1'b1);
    mem[{a[6:1], 1'b0}] = 8'h5A;
    mem[{a[6:1], 1'b1}] = d;
    eei_master_inst.sel(1'b1);
    eei_master_inst.sh(9, {23'h0, 3'b110, a[6:1]}, q);
    chk("wdummy", q[0], 1'b0);
    eei_master_inst.sh(16, 32'h0, q);
    chk("wdata", q[15:0], {mem[{a[6:1], 1'b0}], mem[{a[6:1], 1'b1}]});
    eei_master_inst.sel(1'b0);
    org <= 1'b0;
    op(19, {13'h0, 3'b101, 7'h05, 8'h00, 1'b0}, 1'b0);
    rd(4, 2);
    op(10, {22'h0, 3'b111, a}, 1'b1);
    mem[a] = 8'hFF;
    rd(int'(a) + 127, 3);
    $display("test write erase done");
    d = 8'($urandom);
    op(18, {14'h0, 3'b100, 7'h20, d}, 1'b1);
    foreach (mem[i]) mem[i] = d;
    rd(127, 2);
    op(10, {22'h0, 3'b100, 7'h40}, 1'b1);
    foreach (mem[i]) mem[i] = 8'hFF;
    rd(0, 2);
    rst_b_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    #1 chk("wen_rst2", wen, 1'b0);
    op(10, {22'h0, 3'b100, 7'h60}, 1'b0);
    chk("wen2", wen, 1'b1);
    op(10, {22'h0, 3'b100, 7'h00}, 1'b0);
    chk("wds", wen, 1'b0);
    $display("test array ops done");
    finish_test;
  end
endmodule
`default_nettype wire
